// file: design/lookup_key_if.sv
// lookup key carried from the table to each entry matcher
interface lookup_key_if;
	logic [static_table_pkg::MAC_W-1:0] mac;
	logic [static_table_pkg::GROUP_W-1:0] group;
	modport drive (output mac, output group);
	modport watch (input mac, input group);
endinterface

// file: design/static_entry_match.sv
// compares one static entry against the lookup key
module static_entry_match
(
	lookup_key_if.watch key,
	input wire logic [static_table_pkg::ENTRY_W-1:0] i_entry,
	output logic o_hit
);
	logic mac_eq;
	logic group_eq;

	assign mac_eq = (i_entry[static_table_pkg::MAC_HI:static_table_pkg::MAC_LO] == key.mac);
	assign group_eq = (i_entry[static_table_pkg::GROUP_HI:static_table_pkg::GROUP_LO] == key.group);
	// group joins the key only when the entry asks for it
	// an entry without its valid bit never hits
	assign o_hit = i_entry[static_table_pkg::VALID_BIT] && mac_eq
		&& (!i_entry[static_table_pkg::MATCH_GROUP_BIT] || group_eq);
endmodule // static_entry_match

// file: design/static_mac_forwarding_table.sv
// static mac address table of a three-port switch and its forwarding decision
// What this block does
// - a destination lookup consults both the static table and the dynamic table result before deciding.
// - a source lookup uses the dynamic table alone, the static table takes no part.
// - when the destination hits in both tables, the static result wins.
// - the device never removes or ages static entries; only the host and reset change them.
// - each entry holds a four-bit filter group above a 48-bit mac, the group resetting to zero.
// - entry bit 53 set makes the lookup compare group plus mac, clear compares mac alone.
// - entry bit 52 set lets matching frames pass despite disabled port transmit or receive.
// - an entry is used only when bit 51 is set, and that bit resets to zero.
// - entry bits 50 to 48 are the destination port mask, lowest bit port one.
// - a mask of all ones sends the frame to every port except its ingress port.
// - frames with an invalid vlan id go to the ports in the three-bit mask at bits 6 to 4 of 0xC6.
module static_mac_forwarding_table
(
	input wire logic i_clk,
	input wire logic i_rst,
	// management register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// lookup request
	input wire logic i_lk_valid,
	input wire logic i_lk_source,
	input wire logic [static_table_pkg::MAC_W-1:0] i_lk_mac,
	input wire logic [static_table_pkg::GROUP_W-1:0] i_lk_group,
	input wire logic [static_table_pkg::PORT_NUM_W-1:0] i_lk_ingress,
	input wire logic i_lk_bad_vlan,
	input wire logic i_dyn_hit,
	input wire logic [static_table_pkg::NUM_PORTS-1:0] i_dyn_ports,
	// forwarding decision
	output logic o_fwd_valid,
	output logic [static_table_pkg::NUM_PORTS-1:0] o_fwd_ports,
	output logic o_fwd_static_hit,
	output logic o_fwd_override,
	output logic o_fwd_miss
);
	logic [static_table_pkg::ENTRY_W-1:0] table_mem [static_table_pkg::NUM_ENTRIES];
	logic [static_table_pkg::BUF_W-1:0] data_buf;
	logic [7:0] tbl_ctrl;
	logic [static_table_pkg::NUM_PORTS-1:0] bad_vlan_forward_mask;

	logic trig_wr;
	logic static_sel;
	logic table_write;
	logic table_read;
	logic [static_table_pkg::IDX_W-1:0] trig_idx;
	logic data_wr;
	logic [static_table_pkg::IDX_W-1:0] data_byte;
	logic [static_table_pkg::IDX_W-1:0] rd_byte;

	logic s1_valid;
	logic s1_source;
	logic s1_bad_vlan;
	logic [static_table_pkg::NUM_PORTS-1:0] s1_ingress_oh;
	logic s1_dyn_hit;
	logic [static_table_pkg::NUM_PORTS-1:0] s1_dyn_ports;

	logic [static_table_pkg::NUM_ENTRIES-1:0] entry_hit;
	logic any_hit;
	logic [static_table_pkg::IDX_W-1:0] hit_idx;
	logic [static_table_pkg::ENTRY_W-1:0] hit_entry;
	logic [static_table_pkg::NUM_PORTS-1:0] hit_ports;
	logic [static_table_pkg::NUM_PORTS-1:0] next_static_ports;

	lookup_key_if key_bus ();

	// host access decode
	assign trig_wr = i_reg_wr && (i_reg_addr == static_table_pkg::ADDR_TBL_TRIG);
	assign static_sel = (tbl_ctrl[static_table_pkg::TBL_SEL_HI:static_table_pkg::TBL_SEL_LO]
		== static_table_pkg::TBL_SEL_STATIC);
	assign trig_idx = i_reg_wdata[static_table_pkg::IDX_W-1:0];
	// apart from reset, only the host trigger ever alters an entry
	assign table_write = trig_wr && static_sel && !tbl_ctrl[static_table_pkg::CTRL_READ_BIT];
	assign table_read = trig_wr && static_sel && tbl_ctrl[static_table_pkg::CTRL_READ_BIT];
	assign data_wr = i_reg_wr && (i_reg_addr >= static_table_pkg::ADDR_DATA_FIRST)
		&& (i_reg_addr <= static_table_pkg::ADDR_DATA_LAST);
	assign data_byte = static_table_pkg::IDX_W'(i_reg_addr - static_table_pkg::ADDR_DATA_FIRST);
	assign rd_byte = data_byte;

	// table control register
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			tbl_ctrl <= static_table_pkg::CTRL_RESET;
		end
		else if (i_reg_wr && (i_reg_addr == static_table_pkg::ADDR_TBL_CTRL))
		begin
			tbl_ctrl <= i_reg_wdata & static_table_pkg::CTRL_WR_MASK;
		end
	end

	// invalid vlan forwarding mask
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			bad_vlan_forward_mask <= static_table_pkg::BAD_VLAN_RESET;
		end
		else if (i_reg_wr && (i_reg_addr == static_table_pkg::ADDR_BAD_VLAN))
		begin
			bad_vlan_forward_mask <= i_reg_wdata[static_table_pkg::BAD_VLAN_HI:static_table_pkg::BAD_VLAN_LO];
		end
	end

	// staging buffer behind the eight data registers; bits above the entry stay zero
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			data_buf <= static_table_pkg::BUF_RESET;
		end
		else if (table_read)
		begin
			data_buf <= static_table_pkg::BUF_W'(table_mem[trig_idx]);
		end
		else if (data_wr)
		begin
			data_buf[(static_table_pkg::NUM_ENTRIES - 1 - int'(data_byte)) * static_table_pkg::BYTE_W
				+: static_table_pkg::BYTE_W] <= i_reg_wdata;
			data_buf[static_table_pkg::BUF_W-1:static_table_pkg::ENTRY_W] <= '0;
		end
	end

	// entry storage: reset clears group and valid, no aging path exists
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < static_table_pkg::NUM_ENTRIES; i++)
			begin
				table_mem[i] <= static_table_pkg::ENTRY_RESET;
			end
		end
		else if (table_write)
		begin
			table_mem[trig_idx] <= data_buf[static_table_pkg::ENTRY_W-1:0];
		end
	end

	// register read path, answered one cycle after the strobe
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_reg_rdata <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd)
			begin
				if (i_reg_addr == static_table_pkg::ADDR_TBL_CTRL)
				begin
					o_reg_rdata <= tbl_ctrl;
				end
				else if (i_reg_addr == static_table_pkg::ADDR_BAD_VLAN)
				begin
					o_reg_rdata <= 8'h00;
					o_reg_rdata[static_table_pkg::BAD_VLAN_HI:static_table_pkg::BAD_VLAN_LO]
						<= bad_vlan_forward_mask;
				end
				else if ((i_reg_addr >= static_table_pkg::ADDR_DATA_FIRST)
					&& (i_reg_addr <= static_table_pkg::ADDR_DATA_LAST))
				begin
					o_reg_rdata <= data_buf[(static_table_pkg::NUM_ENTRIES - 1 - int'(rd_byte))
						* static_table_pkg::BYTE_W +: static_table_pkg::BYTE_W];
				end
				else
				begin
					o_reg_rdata <= 8'h00;
				end
			end
		end
	end

	// lookup stage one: capture the request and drive the key to the matchers
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s1_valid <= 1'b0;
			s1_source <= 1'b0;
			s1_bad_vlan <= 1'b0;
			s1_ingress_oh <= '0;
			s1_dyn_hit <= 1'b0;
			s1_dyn_ports <= '0;
			key_bus.mac <= '0;
			key_bus.group <= '0;
		end
		else
		begin
			s1_valid <= i_lk_valid;
			if (i_lk_valid)
			begin
				s1_source <= i_lk_source;
				s1_bad_vlan <= i_lk_bad_vlan;
				s1_ingress_oh <= static_table_pkg::NUM_PORTS'(1) << i_lk_ingress;
				s1_dyn_hit <= i_dyn_hit;
				s1_dyn_ports <= i_dyn_ports;
				key_bus.mac <= i_lk_mac;
				key_bus.group <= i_lk_group;
			end
		end
	end

	// every entry compared in parallel
	for (genvar g = 0; g < static_table_pkg::NUM_ENTRIES; g++)
	begin : g_match
		static_entry_match u_match
		(
			.key (key_bus.watch),
			.i_entry (table_mem[g]),
			.o_hit (entry_hit[g])
		);
	end

	// lowest-numbered hit wins: scan downward so the lowest assignment stands last
	always_comb
	begin
		hit_idx = '0;
		for (int i = static_table_pkg::NUM_ENTRIES - 1; i >= 0; i--)
		begin
			if (entry_hit[i])
			begin
				hit_idx = static_table_pkg::IDX_W'(i);
			end
		end
	end

	assign any_hit = |entry_hit;
	assign hit_entry = table_mem[hit_idx];
	assign hit_ports = hit_entry[static_table_pkg::PORTS_HI:static_table_pkg::PORTS_LO];

	// all-ones mask floods to everything but the ingress port
	always_comb
	begin
		if (hit_ports == static_table_pkg::PORTS_ALL)
		begin
			next_static_ports = static_table_pkg::PORTS_ALL & ~s1_ingress_oh;
		end
		else
		begin
			next_static_ports = hit_ports;
		end
	end

	// lookup stage two: the forwarding decision
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_fwd_valid <= 1'b0;
			o_fwd_ports <= '0;
			o_fwd_static_hit <= 1'b0;
			o_fwd_override <= 1'b0;
			o_fwd_miss <= 1'b0;
		end
		else
		begin
			o_fwd_valid <= s1_valid;
			if (s1_valid)
			begin
				if (s1_bad_vlan)
				begin
					o_fwd_ports <= bad_vlan_forward_mask;
					o_fwd_static_hit <= 1'b0;
					o_fwd_override <= 1'b0;
					o_fwd_miss <= 1'b0;
				end
				else if (s1_source)
				begin
					// source lookups ignore the static table entirely
					o_fwd_ports <= s1_dyn_ports;
					o_fwd_static_hit <= 1'b0;
					o_fwd_override <= 1'b0;
					o_fwd_miss <= !s1_dyn_hit;
				end
				else if (any_hit)
				begin
					// static result overrides any dynamic hit
					o_fwd_ports <= next_static_ports;
					o_fwd_static_hit <= 1'b1;
					o_fwd_override <= hit_entry[static_table_pkg::OVERRIDE_BIT];
					o_fwd_miss <= 1'b0;
				end
				else if (s1_dyn_hit)
				begin
					o_fwd_ports <= s1_dyn_ports;
					o_fwd_static_hit <= 1'b0;
					o_fwd_override <= 1'b0;
					o_fwd_miss <= 1'b0;
				end
				else
				begin
					// miss in both tables: caller falls back to vlan membership
					o_fwd_ports <= '0;
					o_fwd_static_hit <= 1'b0;
					o_fwd_override <= 1'b0;
					o_fwd_miss <= 1'b1;
				end
			end
		end
	end
endmodule // static_mac_forwarding_table

// file: design/static_table_pkg.sv
// constants shared by the static address table and its entry matchers
package static_table_pkg;
	localparam int NUM_ENTRIES = 8;
	localparam int IDX_W = 3;
	localparam int ENTRY_W = 58;
	localparam int BUF_W = 64;
	localparam int NUM_PORTS = 3;
	localparam int PORT_NUM_W = 2;
	localparam int MAC_W = 48;
	localparam int GROUP_W = 4;
	localparam int BYTE_W = 8;

	// entry field layout
	localparam int GROUP_HI = 57;
	localparam int GROUP_LO = 54;
	localparam int MATCH_GROUP_BIT = 53;
	localparam int OVERRIDE_BIT = 52;
	localparam int VALID_BIT = 51;
	localparam int PORTS_HI = 50;
	localparam int PORTS_LO = 48;
	localparam int MAC_HI = 47;
	localparam int MAC_LO = 0;
	localparam logic [NUM_PORTS-1:0] PORTS_ALL = 3'h7;
	localparam logic [ENTRY_W-1:0] ENTRY_RESET = 58'h0;

	// register addresses
	localparam logic [7:0] ADDR_TBL_CTRL = 8'h79;
	localparam logic [7:0] ADDR_TBL_TRIG = 8'h7A;
	localparam logic [7:0] ADDR_DATA_FIRST = 8'h7C;
	localparam logic [7:0] ADDR_DATA_LAST = 8'h83;
	localparam logic [7:0] ADDR_BAD_VLAN = 8'hC6;

	// table control register fields
	localparam int CTRL_READ_BIT = 4;
	localparam int TBL_SEL_HI = 3;
	localparam int TBL_SEL_LO = 2;
	localparam logic [1:0] TBL_SEL_STATIC = 2'h0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WR_MASK = 8'h1F;

	// invalid vlan forwarding register fields
	localparam int BAD_VLAN_HI = 6;
	localparam int BAD_VLAN_LO = 4;
	localparam logic [NUM_PORTS-1:0] BAD_VLAN_RESET = 3'h0;
	localparam logic [BUF_W-1:0] BUF_RESET = 64'h0;
endpackage

// file: test/host_reg_model.sv
// host processor model driving the management register port
module host_reg_model
(
	input wire logic i_clk,
	output logic [7:0] o_reg_addr,
	output logic o_reg_wr,
	output logic [7:0] o_reg_wdata,
	output logic o_reg_rd,
	input wire logic [7:0] i_reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{o_reg_addr, o_reg_wr, o_reg_wdata, o_reg_rd} = 18'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		{o_reg_addr, o_reg_wdata, o_reg_wr} = {a, d, 1'h1};
		@(posedge i_clk);
		#1;
		o_reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		#1;
		{o_reg_addr, o_reg_rd} = {a, 1'h1};
		@(posedge i_clk);
		#1;
		o_reg_rd = 1'h0;
		d = i_reg_rdata;
	endtask
	// entries change only through staging bytes plus trigger
	task automatic write_entry(input logic [2:0] idx, input logic [57:0] e);
		logic [63:0] b;
		b = {6'h00, e};
		for (int k = 0; k < 8; k++)
			wr(8'h7C + 8'(k), b[63-8*k -: 8]);
		wr(8'h79, 8'h00);
		wr(8'h7A, {5'h00, idx});
	endtask
	task automatic read_entry(input logic [2:0] idx, output logic [57:0] e);
		logic [63:0] b;
		logic [7:0] d;
		wr(8'h79, 8'h10);
		wr(8'h7A, {5'h00, idx});
		for (int k = 0; k < 8; k++)
		begin
			rd(8'h7C + 8'(k), d);
			b[63-8*k -: 8] = d;
		end
		e = b[57:0];
	endtask
endmodule // host_reg_model

// file: test/static_mac_forwarding_table_bench.sv
// self-checking bench for the static mac forwarding table
module static_mac_forwarding_table_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [47:0] MAC_A = 48'h0123456789AB;
	logic i_clk, i_rst, reg_wr, reg_rd, reg_rvalid, lk_valid, lk_source, lk_bad_vlan, dyn_hit;
	logic fwd_valid, fwd_static_hit, fwd_override, fwd_miss;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [47:0] lk_mac;
	logic [3:0] lk_group;
	logic [1:0] lk_ingress;
	logic [2:0] dyn_ports, fwd_ports;
	logic [57:0] ent;
	int errors, total_checks;
	static_mac_forwarding_table static_mac_forwarding_table_inst (.i_clk, .i_rst, .i_reg_addr(reg_addr),
		.i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
		.o_reg_rvalid(reg_rvalid), .i_lk_valid(lk_valid), .i_lk_source(lk_source), .i_lk_mac(lk_mac),
		.i_lk_group(lk_group), .i_lk_ingress(lk_ingress), .i_lk_bad_vlan(lk_bad_vlan), .i_dyn_hit(dyn_hit),
		.i_dyn_ports(dyn_ports), .o_fwd_valid(fwd_valid), .o_fwd_ports(fwd_ports),
		.o_fwd_static_hit(fwd_static_hit), .o_fwd_override(fwd_override), .o_fwd_miss(fwd_miss));
	host_reg_model host_reg_model_inst (.i_clk, .o_reg_addr(reg_addr), .o_reg_wr(reg_wr),
		.o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd), .i_reg_rdata(reg_rdata));
	initial
	begin
		i_clk = 1'h0;
		forever #2.5 i_clk = ~i_clk;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// exp packs ports, static hit, override, miss
	task automatic lk(input logic src, input logic [47:0] mac, input logic [3:0] grp, input logic [1:0] ing,
		input logic bad, input logic dh, input logic [2:0] dp, input logic [5:0] exp);
		int n;
		@(posedge i_clk);
		#1;
		{lk_valid, lk_source, lk_mac, lk_group, lk_ingress, lk_bad_vlan, dyn_hit, dyn_ports} =
			{1'h1, src, mac, grp, ing, bad, dh, dp};
		@(posedge i_clk);
		#1;
		lk_valid = 1'h0;
		n = 0;
		while (fwd_valid !== 1'h1 && n < 4)
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n == 4)
		begin
			errors++;
			end_of_test();
		end
		chk({fwd_ports, fwd_static_hit, fwd_override, fwd_miss}, exp);
	endtask
	task automatic t_reset;
		host_reg_model_inst.rd(8'hC6, d);
		chk(d, 8'h00);
		chk(reg_rvalid, 1'h1);
		host_reg_model_inst.read_entry(3'h0, ent);
		chk(ent, 58'h0);
		$display("reset values done");
	endtask
	task automatic t_table;
		host_reg_model_inst.write_entry(3'h7, 58'h2BD0123456789AB);
		host_reg_model_inst.read_entry(3'h7, ent);
		chk(ent, 58'h2BD0123456789AB);
		lk(1'h0, MAC_A, 4'hA, 2'h0, 1'h0, 1'h0, 3'h0, 6'h2E);
		lk(1'h0, MAC_A, 4'hB, 2'h0, 1'h0, 1'h1, 3'h2, 6'h10);
		lk(1'h0, MAC_A, 4'hA, 2'h0, 1'h0, 1'h1, 3'h2, 6'h2E);
		lk(1'h1, MAC_A, 4'hA, 2'h0, 1'h0, 1'h0, 3'h3, 6'h19);
		lk(1'h0, 48'h0123456789AC, 4'hA, 2'h0, 1'h0, 1'h1, 3'h4, 6'h20);
		$display("table and lookup done");
	endtask
	task automatic t_priority;
		host_reg_model_inst.write_entry(3'h1, 58'h0010123456789AB);
		lk(1'h0, MAC_A, 4'hB, 2'h0, 1'h0, 1'h1, 3'h2, 6'h10);
		host_reg_model_inst.write_entry(3'h2, 58'h00F0123456789AB);
		lk(1'h0, MAC_A, 4'hB, 2'h1, 1'h0, 1'h0, 3'h0, 6'h2C);
		lk(1'h0, MAC_A, 4'hA, 2'h2, 1'h0, 1'h1, 3'h4, 6'h1C);
		$display("entry priority done");
	endtask
	// a trigger with another table selected must leave entry 7 alone while staging holds entry 2
	task automatic t_table_select;
		host_reg_model_inst.wr(8'h79, 8'hE4);
		host_reg_model_inst.rd(8'h79, d);
		chk(d, 8'h04);
		host_reg_model_inst.wr(8'h7A, 8'h07);
		host_reg_model_inst.rd(8'h7A, d);
		chk(d, 8'h00);
		host_reg_model_inst.read_entry(3'h7, ent);
		chk(ent, 58'h2BD0123456789AB);
		$display("table select done");
	endtask
	task automatic t_bad_vlan;
		host_reg_model_inst.wr(8'hC6, 8'hFF);
		host_reg_model_inst.rd(8'hC6, d);
		chk(d, 8'h70);
		lk(1'h0, MAC_A, 4'hA, 2'h0, 1'h1, 1'h1, 3'h1, 6'h38);
		host_reg_model_inst.wr(8'hC6, 8'h50);
		lk(1'h1, MAC_A, 4'hA, 2'h0, 1'h1, 1'h1, 3'h1, 6'h28);
		$display("bad vlan done");
	endtask
	task automatic t_persist;
		repeat (400) @(posedge i_clk);
		lk(1'h0, MAC_A, 4'hA, 2'h0, 1'h0, 1'h0, 3'h0, 6'h34);
		$display("persistence done");
	endtask
	initial
	begin
		errors = 0;
		total_checks = 0;
		i_rst = 1'h1;
		{lk_valid, lk_source, lk_mac, lk_group, lk_ingress, lk_bad_vlan, dyn_hit, dyn_ports} = 61'h0;
		repeat (8) @(posedge i_clk);
		#1;
		i_rst = 1'h0;
		t_reset();
		t_table();
		t_priority();
		t_table_select();
		t_bad_vlan();
		t_persist();
		end_of_test();
	end
endmodule // static_mac_forwarding_table_bench

// file: test/static_table_props.sv
// concurrent checks on the static table ports
module static_table_props
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_reg_rvalid,
	input wire logic i_lk_valid,
	input wire logic i_lk_source,
	input wire logic i_lk_bad_vlan,
	input wire logic i_dyn_hit,
	input wire logic [static_table_pkg::NUM_PORTS-1:0] i_dyn_ports,
	input wire logic o_fwd_valid,
	input wire logic [static_table_pkg::NUM_PORTS-1:0] o_fwd_ports,
	input wire logic o_fwd_static_hit,
	input wire logic o_fwd_override,
	input wire logic o_fwd_miss
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_dest;
		i_lk_valid && !i_lk_bad_vlan && !i_lk_source;
	endsequence
	sequence s_src;
		i_lk_valid && !i_lk_bad_vlan && i_lk_source;
	endsequence
	a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read not answered");
	a_answer_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
		else $error("answer without read");
	a_trigger_reads: assert property (i_reg_rd && i_reg_addr == 8'h7A |=> o_reg_rdata == 8'h00)
		else $error("trigger register not zero");
	a_mask_reads: assert property (i_reg_rd && i_reg_addr == 8'hC6 |=> (o_reg_rdata & 8'h8F) == 8'h00)
		else $error("stray bits in mask register");
	a_decide_latency: assert property (i_lk_valid |-> ##2 o_fwd_valid)
		else $error("decision late");
	a_decide_cause: assert property (o_fwd_valid |-> $past(i_lk_valid, 2))
		else $error("decision without request");
	a_bad_vlan_plain: assert property (i_lk_valid && i_lk_bad_vlan |-> ##2
		!(o_fwd_static_hit || o_fwd_override || o_fwd_miss))
		else $error("bad vlan flags set");
	a_source_dynamic: assert property (s_src |-> ##2 (o_fwd_ports == $past(i_dyn_ports, 2)
		&& o_fwd_miss != $past(i_dyn_hit, 2) && !o_fwd_static_hit))
		else $error("source lookup wrong");
	a_dest_miss: assert property (s_dest ##0 !i_dyn_hit |-> ##2 o_fwd_miss != o_fwd_static_hit)
		else $error("miss flag wrong");
	a_static_wins: assert property (s_dest ##0 i_dyn_hit |-> ##2 (!o_fwd_miss
		&& (o_fwd_static_hit || o_fwd_ports == $past(i_dyn_ports, 2))))
		else $error("dynamic result wrong");
	a_override_static: assert property (o_fwd_valid && o_fwd_override |-> o_fwd_static_hit)
		else $error("override without static hit");
endmodule // static_table_props

bind static_mac_forwarding_table static_table_props static_table_props_inst (.i_clk, .i_rst, .i_reg_addr,
	.i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_lk_valid, .i_lk_source, .i_lk_bad_vlan, .i_dyn_hit,
	.i_dyn_ports, .o_fwd_valid, .o_fwd_ports, .o_fwd_static_hit, .o_fwd_override, .o_fwd_miss);
